// File: logic/ants_supervisor.sv
`timescale 1ns/100ps
`include "ants_cfg.svh"
module ants_supervisor
  import ants_pkg::*;
#(
  parameter int unsigned               RETEST_CYCLES = `ANTS_RETEST_CYCLES,
  parameter logic [`ANTS_CTRL_W-1:0]   STORED_CFG    = `ANTS_CTRL_RESET
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        short_sense_low,
  input  wire logic        presence_sense_pin,
  output logic             antenna_power_cutoff,
  output logic             short_pullup_en,
  output logic             presence_pullup_en,
  output ants_cond_rpt_t   antenna_condition_report,
  output ants_feat_rpt_t   supervisor_feature_report
);

  localparam int unsigned SETTLE = `ANTS_SETTLE_CYCLES;

  logic [1:0]  rst_pipe;
  logic        rst_n;
  logic [1:0]  short_sync;
  logic [1:0]  pres_sync;
  logic [1:0]  short_en_q;
  logic [1:0]  pres_en_q;
  ants_ctrl_t  ctrl;
  ants_ctrl_t  feat_snap;
  logic        feat_done;
  ants_state_t state;
  ants_state_t next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        reported;
  ants_cond_t  last_cond;
  logic        last_pwr;
  logic        changed;

  function automatic logic addr_ok(input logic [11:0] a);
    return (a == `ANTS_CTRL_OFS) || (a == `ANTS_STATUS_OFS) || (a == `ANTS_FEATURES_OFS);
  endfunction

  function automatic ants_cond_t cond_of(input ants_state_t s);
    ants_cond_t c;
    c = COND_SHORT;
    if (s == ST_INIT) c = COND_INIT;
    else if (s == ST_OK) c = COND_OK;
    else if (s == ST_OPEN) c = COND_OPEN;
    return c;
  endfunction

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) rst_pipe <= 2'b00;
    else rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n = rst_pipe[1];

  // Idle levels match the pull-ups, so no false event at release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      short_sync <= 2'b11;
      pres_sync  <= 2'b11;
    end else begin
      short_sync <= {short_sync[0], short_sense_low};
      pres_sync  <= {pres_sync[0], presence_sense_pin};
    end
  end

  // Enables lag like the pins: samples taken before the pull-up was on are stale
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      short_en_q <= 2'b00;
      pres_en_q  <= 2'b00;
    end else begin
      short_en_q <= {short_en_q[0], ctrl.short_detect_enable};
      pres_en_q  <= {pres_en_q[0], ctrl.open_detect_enable};
    end
  end

  wire logic short_seen = ctrl.short_detect_enable & short_en_q[1] & ~short_sync[1];
  wire logic open_seen  = ctrl.open_detect_enable & pres_en_q[1] & ~pres_sync[1];
  wire logic cut_mode   = ctrl.power_down_on_short & ctrl.short_recovery_enable;

  // APB: data and error captured in setup, answered in first access cycle
  wire logic apb_setup = psel & ~penable;
  wire logic apb_acc   = psel & penable;
  wire logic wr_ctrl   = apb_acc & pwrite & (paddr == `ANTS_CTRL_OFS);
  wire logic wr_stat   = apb_acc & pwrite & (paddr == `ANTS_STATUS_OFS);
  wire logic clr_chg   = wr_stat & pwdata[`ANTS_ST_CHANGED];

  wire ants_cond_t cur_cond = cond_of(state);
  wire logic       cur_pwr  = (state != ST_CUT);

  wire logic [31:0] status_word = {23'h000000, changed, 2'b00, pres_sync[1],
                                   short_sync[1], ctrl.supply_control_enable,
                                   cur_pwr, cur_cond};
  wire logic [31:0] rd_mux =
    (paddr == `ANTS_CTRL_OFS)     ? {27'h0000000, ctrl} :
    (paddr == `ANTS_STATUS_OFS)   ? status_word :
    (paddr == `ANTS_FEATURES_OFS) ? {27'h0000000, feat_snap} : 32'h00000000;

  assign pready = apb_acc;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata  <= rd_mux;
      pslverr <= ~addr_ok(paddr);
    end
  end

  // Control register; reset value stands for the stored configuration
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) ctrl <= ants_ctrl_t'(STORED_CFG);
    else if (wr_ctrl) ctrl <= ants_ctrl_t'(pwdata[`ANTS_CTRL_W-1:0]);
  end

  assign short_pullup_en    = ctrl.short_detect_enable;
  assign presence_pullup_en = ctrl.open_detect_enable;

  // Live evaluation when not latched; short has priority over open
  function automatic ants_state_t live_eval(input logic sh, input logic op, input logic cm);
    ants_state_t s;
    s = ST_OK;
    if (sh) s = cm ? ST_CUT : ST_SHORT;
    else if (op) s = ST_OPEN;
    return s;
  endfunction

  wire logic settled   = (cnt >= SETTLE - 1);
  wire logic timed_out = (cnt >= RETEST_CYCLES - 1);

  always_comb begin
    next_state = state;
    if (!ctrl.supply_control_enable) begin
      next_state = ST_INIT;
    end else begin
      unique case (state)
        ST_INIT: begin
          if (settled) next_state = live_eval(short_seen, open_seen, cut_mode);
        end
        ST_OK, ST_OPEN: begin
          next_state = live_eval(short_seen, open_seen, cut_mode);
        end
        ST_SHORT: begin
          // Latched: leaves only on supply control or detect disable, or recovery timeout
          if (!ctrl.short_detect_enable) next_state = ST_OK;
          else if (ctrl.short_recovery_enable && timed_out && !short_seen)
            next_state = ST_OK;
        end
        ST_CUT: begin
          if (!ctrl.short_detect_enable) next_state = ST_OK;
          else if (!cut_mode) next_state = ST_SHORT;
          else if (timed_out) next_state = ST_RETEST;
        end
        ST_RETEST: begin
          if (!ctrl.short_detect_enable) next_state = ST_OK;
          else if (short_seen) next_state = cut_mode ? ST_CUT : ST_SHORT;
          else if (settled) next_state = ST_OK;
        end
      endcase
    end
  end

  // Timer restarts on every state change and while supply control is off
  assign next_cnt = (next_state != state || !ctrl.supply_control_enable) ? 32'h00000000 :
                    (cnt == 32'hffffffff) ? cnt : cnt + 32'h00000001;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state                <= ST_INIT;
      cnt                  <= 32'h00000000;
      antenna_power_cutoff <= 1'b0;
    end else begin
      state                <= next_state;
      cnt                  <= next_cnt;
      antenna_power_cutoff <= (next_state == ST_CUT);
    end
  end

  // Condition reports: first one after enable is INIT, then each change
  wire logic rpt_fire = ctrl.supply_control_enable &
                        (!reported || cur_cond != last_cond || cur_pwr != last_pwr);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reported                 <= 1'b0;
      last_cond                <= COND_INIT;
      last_pwr                 <= 1'b1;
      antenna_condition_report <= '0;
    end else begin
      reported                       <= ctrl.supply_control_enable;
      last_cond                      <= cur_cond;
      last_pwr                       <= cur_pwr;
      antenna_condition_report.valid <= rpt_fire;
      antenna_condition_report.cond  <= cur_cond;
      antenna_condition_report.power_on <= cur_pwr;
    end
  end

  // Sticky change flag; a new report beats a same-cycle clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) changed <= 1'b0;
    else if (rpt_fire) changed <= 1'b1;
    else if (clr_chg) changed <= 1'b0;
  end

  // Feature summary once after reset, only when supply control is stored on
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      feat_done                 <= 1'b0;
      feat_snap                 <= '0;
      supervisor_feature_report <= '0;
    end else begin
      feat_done                       <= 1'b1;
      supervisor_feature_report.valid <= !feat_done && ctrl.supply_control_enable;
      supervisor_feature_report.features <= ctrl;
      if (!feat_done) feat_snap <= ctrl;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_cut_then_power_off;
    (state == ST_CUT) ##0 antenna_power_cutoff ##1 antenna_condition_report.valid;
  endsequence

  sequence s_retest_power_on;
    (state == ST_RETEST) && !antenna_power_cutoff;
  endsequence

  property p_no_report_when_off;
    !ctrl.supply_control_enable |=> !antenna_condition_report.valid;
  endproperty
  a_no_report_when_off: assert property (p_no_report_when_off)
    else $error("condition report while supply control off");

  property p_cutoff_matches_state;
    antenna_power_cutoff == (state == ST_CUT);
  endproperty
  a_cutoff_matches_state: assert property (p_cutoff_matches_state)
    else $error("cutoff output disagrees with state");

  property p_short_detect;
    (state == ST_OK) && ctrl.supply_control_enable && ctrl.short_detect_enable
      && short_en_q[1] && !short_sync[1] |=> (state == ST_SHORT || state == ST_CUT);
  endproperty
  a_short_detect: assert property (p_short_detect)
    else $error("low short sense not taken as short");

  property p_short_keeps_power;
    (state == ST_SHORT) |=> !antenna_power_cutoff ##1
      (!antenna_condition_report.valid || antenna_condition_report.power_on);
  endproperty
  a_short_keeps_power: assert property (p_short_keeps_power)
    else $error("power cut without power-down on short");

  property p_short_latched;
    (state == ST_SHORT) && ctrl.supply_control_enable && ctrl.short_detect_enable
      && !ctrl.short_recovery_enable |=> (state == ST_SHORT);
  endproperty
  a_short_latched: assert property (p_short_latched)
    else $error("short condition released without cause");

  property p_cut_on_short;
    (state == ST_OK) && ctrl.supply_control_enable && short_seen && cut_mode
      |=> s_cut_then_power_off ##0 !antenna_condition_report.power_on
      ##0 (antenna_condition_report.cond == COND_SHORT);
  endproperty
  a_cut_on_short: assert property (p_cut_on_short)
    else $error("short with recovery did not cut power");

  property p_retest_after_timeout;
    (state == ST_CUT) && ctrl.supply_control_enable && ctrl.short_detect_enable
      && cut_mode && (cnt == RETEST_CYCLES - 1) |=> s_retest_power_on;
  endproperty
  a_retest_after_timeout: assert property (p_retest_after_timeout)
    else $error("retest not started after timeout");

  property p_open_detect;
    (state == ST_OK) && ctrl.supply_control_enable && !short_seen
      && ctrl.open_detect_enable && pres_en_q[1] && !pres_sync[1] |=> (state == ST_OPEN);
  endproperty
  a_open_detect: assert property (p_open_detect)
    else $error("low presence sense not taken as open");

  property p_open_recover;
    (state == ST_OPEN) && ctrl.supply_control_enable && !short_seen && pres_sync[1]
      |=> (state == ST_OK) ##1 (antenna_condition_report.cond == COND_OK);
  endproperty
  a_open_recover: assert property (p_open_recover)
    else $error("open condition did not return to ok");

  property p_init_first;
    $rose(ctrl.supply_control_enable) |=> antenna_condition_report.valid
      && (antenna_condition_report.cond == COND_INIT);
  endproperty
  a_init_first: assert property (p_init_first)
    else $error("first report after enable is not init");

endmodule

// File: common/ants_cfg.svh
`ifndef ANTS_CFG_SVH
`define ANTS_CFG_SVH

// Register byte offsets
`define ANTS_CTRL_OFS      12'h000
`define ANTS_STATUS_OFS    12'h004
`define ANTS_FEATURES_OFS  12'h008

// Control and feature bit positions
`define ANTS_BIT_AC        0
`define ANTS_BIT_SD        1
`define ANTS_BIT_SR        2
`define ANTS_BIT_OD        3
`define ANTS_BIT_POWER_DOWN_ON_SHORT      4
`define ANTS_CTRL_W        5
`define ANTS_CTRL_RESET    5'h00

// Status bit positions
`define ANTS_ST_COND_LSB   0
`define ANTS_ST_POWER      2
`define ANTS_ST_REPORTING  3
`define ANTS_ST_SHORT_RAW  4
`define ANTS_ST_PRES_RAW   5
`define ANTS_ST_CHANGED    8

// Timing
`define ANTS_CLK_MHZ       100
`define ANTS_SETTLE_NS     1000
`define ANTS_SETTLE_CYCLES ((`ANTS_SETTLE_NS * `ANTS_CLK_MHZ + 999) / 1000)
`define ANTS_RETEST_MS     1000
`define ANTS_RETEST_CYCLES (`ANTS_RETEST_MS * 1000 * `ANTS_CLK_MHZ)

`endif

// File: common/ants_pkg.sv
package ants_pkg;

  typedef enum logic [1:0] {
    COND_INIT,
    COND_OK,
    COND_SHORT,
    COND_OPEN
  } ants_cond_t;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_OK,
    ST_OPEN,
    ST_SHORT,
    ST_CUT,
    ST_RETEST
  } ants_state_t;

  // Bit 0 is supply control, matching the control register
  typedef struct packed {
    logic power_down_on_short;
    logic open_detect_enable;
    logic short_recovery_enable;
    logic short_detect_enable;
    logic supply_control_enable;
  } ants_ctrl_t;

  typedef struct packed {
    logic       valid;
    ants_cond_t cond;
    logic       power_on;
  } ants_cond_rpt_t;

  typedef struct packed {
    logic       valid;
    ants_ctrl_t features;
  } ants_feat_rpt_t;

endpackage

// File: verification/ants_antenna_model.sv
`timescale 1ns/100ps
module ants_antenna_model (
  input  wire logic sys_clk,
  input  wire logic short_pullup_en,
  input  wire logic presence_pullup_en,
  input  wire logic antenna_power_cutoff,
  input  wire logic shorted,
  input  wire logic absent,
  output logic      short_sense_low,
  output logic      presence_sense_pin
);
  logic drift = 1'h0;

  // Undriven pins wander, never settle to a kind level
  always @(posedge sys_clk) begin
    drift <= ~drift;
  end

  // Unpowered antenna draws no current, so a short cannot pull low
  assign short_sense_low = (shorted && !antenna_power_cutoff) ? 1'h0 :
                           (short_pullup_en ? 1'h1 : drift);
  assign presence_sense_pin = absent ? 1'h0 : (presence_pullup_en ? 1'h1 : drift);
endmodule

// File: verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import ants_pkg::*;
  typedef struct {
    logic [4:0] c;
    logic       sh;
    logic       ab;
    int         w;
    logic [2:0] st;
    logic       cut;
  } ants_row_t;
  logic sys_clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic shorted = 1'h0, absent = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, short_sense_low, presence_sense_pin, antenna_power_cutoff;
  logic short_pullup_en, presence_pullup_en, rpt_pwr;
  logic [4:0] feat_val;
  ants_cond_rpt_t antenna_condition_report;
  ants_feat_rpt_t supervisor_feature_report;
  ants_cond_t rq[$];
  int mismatches = 0, total_checks = 0, feat_seen = 0, n;
  // Columns: ctrl, short, absent, wait, {power_on, cond}, cutoff
  ants_row_t rows[10] = '{
    '{5'h00, 1'h0, 1'h0, 150, 3'h4, 1'h0},
    '{5'h03, 1'h0, 1'h0, 150, 3'h5, 1'h0},
    '{5'h03, 1'h1, 1'h0, 150, 3'h6, 1'h0},
    '{5'h03, 1'h0, 1'h0, 150, 3'h6, 1'h0},
    '{5'h01, 1'h0, 1'h0, 150, 3'h5, 1'h0},
    '{5'h09, 1'h0, 1'h1, 150, 3'h7, 1'h0},
    '{5'h09, 1'h0, 1'h0, 150, 3'h5, 1'h0},
    '{5'h1f, 1'h0, 1'h0, 150, 3'h5, 1'h0},
    '{5'h1f, 1'h1, 1'h0, 10, 3'h2, 1'h1},
    '{5'h1f, 1'h0, 1'h0, 250, 3'h5, 1'h0}
  };

  always #5 sys_clk = ~sys_clk;

  ants_supervisor #(.RETEST_CYCLES(50), .STORED_CFG(5'h1f)) i_ants_supervisor (
    .sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .short_sense_low, .presence_sense_pin, .antenna_power_cutoff,
    .short_pullup_en, .presence_pullup_en, .antenna_condition_report,
    .supervisor_feature_report);

  ants_antenna_model i_ants_antenna_model (
    .sys_clk, .short_pullup_en, .presence_pullup_en, .antenna_power_cutoff,
    .shorted, .absent, .short_sense_low, .presence_sense_pin);

  always @(posedge sys_clk) begin
    if (antenna_condition_report.valid === 1'h1) begin
      rq.push_back(antenna_condition_report.cond);
      rpt_pwr = antenna_condition_report.power_on;
    end
    if (supervisor_feature_report.valid === 1'h1) begin
      feat_seen++;
      feat_val = supervisor_feature_report.features;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (k >= 20) chk(32'h0, 32'h1, "pready never came");
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #100000;
    chk(32'h0, 32'h1, "watchdog expired");
    print_verdict;
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'h1;
    repeat (150) @(posedge sys_clk);
    chk(32'(feat_seen), 32'h1, "feature pulses");
    chk(32'(feat_val), 32'h1f, "feature list");
    chk(32'(rq.size()), 32'h2, "startup report count");
    chk(32'({rq[0], rq[1]}), 32'h1, "INIT then OK");
    $display("Startup test done");
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h1f, "ctrl reset value");
    apb(1'h1, 12'h008, 32'h0);
    apb(1'h0, 12'h008, 32'h0);
    chk(rd, 32'h1f, "features read-only");
    apb(1'h0, 12'h00c, 32'h0);
    chk(rd, 32'h0, "unmapped read data");
    chk(32'(err), 32'h1, "unmapped error");
    $display("Register test done");
    foreach (rows[i]) begin
      apb(1'h1, 12'h000, {27'h0, rows[i].c});
      shorted <= rows[i].sh;
      absent <= rows[i].ab;
      repeat (rows[i].w) @(posedge sys_clk);
      apb(1'h0, 12'h004, 32'h0);
      chk(rd & 32'h7, {29'h0, rows[i].st}, "status");
      chk(32'(antenna_power_cutoff), 32'(rows[i].cut), "cutoff");
      chk(32'({presence_pullup_en, short_pullup_en}), 32'({rows[i].c[3], rows[i].c[1]}),
          "pullups");
      chk(32'(rpt_pwr), 32'(rows[i].st[2]), "report power");
      $display("Row %0d done", i);
    end
    apb(1'h1, 12'h000, 32'h0);
    repeat (20) @(posedge sys_clk);
    apb(1'h0, 12'h004, 32'h0);
    chk(32'(rd[8]), 32'h1, "change flag set");
    apb(1'h1, 12'h004, 32'h100);
    apb(1'h0, 12'h004, 32'h0);
    chk(rd & 32'h108, 32'h0, "change flag cleared, supply off");
    n = rq.size();
    shorted <= 1'h1;
    absent <= 1'h1;
    repeat (100) @(posedge sys_clk);
    chk(32'(rq.size()), 32'(n), "report while supply control off");
    chk(32'(antenna_power_cutoff), 32'h0, "cutoff while off");
    $display("Disabled test done");
    print_verdict;
  end
endmodule
